// [an_adv_map.vh]
// Register map and field constants for the auto-negotiation advertisement bank
`ifndef AN_ADV_MAP_VH
`define AN_ADV_MAP_VH

// ----------------------------------------
// Addressing
// ----------------------------------------
`define ADV_ADDR_W 5
`define ADV_DATA_W 16
`define ADV_INDEX 4'h4
`define ADV_PHY_SEL_BIT 4
`define ADV_N_PHY 2
`define ADV_PHY_A 0
`define ADV_PHY_B 1

// ----------------------------------------
// Strap positions within one PHY group
// ----------------------------------------
`define ADV_STRAP_W 6
`define STRAP_MANUAL_FC 5
`define STRAP_FD_FC 4
`define STRAP_AUTONEG 3
`define STRAP_SPEED 2
`define STRAP_DUPLEX 1
`define STRAP_FIBER 0

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ADV_NEXT_PAGE 15
`define ADV_RSVD_14 14
`define ADV_REMOTE_FAULT 13
`define ADV_EXT_NEXT_PAGE 12
`define ADV_ASYM_PAUSE 11
`define ADV_SYM_PAUSE 10
`define ADV_RSVD_9 9
`define ADV_100_FD 8
`define ADV_100_HD 7
`define ADV_10_FD 6
`define ADV_10_HD 5
`define ADV_SEL_HI 4
`define ADV_SEL_LO 0

// ----------------------------------------
// Write mask and fixed reset parts
// ----------------------------------------
`define ADV_WR_MASK 16'hbdff
`define ADV_SEL_RESET 5'h01
`define ADV_FIXED_RESET 16'h0181
`define ADV_ZERO16 16'h0000

`endif

// [phy_autoneg_advert_reg.v]
// Auto-negotiation advertisement registers for two PHYs with strap-derived defaults
//
// Overview of operation
// - Register at index 4, 16 bits, read/write
// - Bit 15 next page, resets 0
// - Bit 13 remote fault, resets 0
// - Bits 11/10 asymmetric and symmetric pause
// - Manual strap 0: sym 1, asym FD strap
// - Manual strap 1: both pause bits 0
// - Fiber mode: pause and 10BASE-T defaults 0
// - Bits 8/7 100BASE-X duplex, reset 1
// - Bit 6 default: an OR (!speed AND duplex)
// - Bit 5 default: an OR !speed
// - Selector bits 4:0 reset to 00001
`timescale 1ns/1ps
`include "an_adv_map.vh"

module phy_autoneg_advert_reg (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Register port: bit 4 of address selects PHY B
  input wire [`ADV_ADDR_W-1:0] reg_addr,
  input wire [`ADV_DATA_W-1:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [`ADV_DATA_W-1:0] reg_rdata,
  // Configuration straps, PHY A
  input wire manual_flow_ctl_cfg_a,
  input wire full_duplex_flow_ctl_cfg_a,
  input wire autoneg_cfg_a,
  input wire speed_cfg_a,
  input wire duplex_cfg_a,
  input wire fiber_mode_a,
  // Configuration straps, PHY B
  input wire manual_flow_ctl_cfg_b,
  input wire full_duplex_flow_ctl_cfg_b,
  input wire autoneg_cfg_b,
  input wire speed_cfg_b,
  input wire duplex_cfg_b,
  input wire fiber_mode_b,
  // Advertised abilities to auto-negotiation
  output wire [`ADV_DATA_W-1:0] advert_a,
  output wire [`ADV_DATA_W-1:0] advert_b
);

  // ----------------------------------------
  // Local sizes
  // ----------------------------------------
  // Two PHYs share one register port; each has six straps
  localparam N_PHY = `ADV_N_PHY;
  localparam STRAP_W = `ADV_STRAP_W;
  localparam SYNC_W = `ADV_N_PHY * `ADV_STRAP_W;
  localparam DATA_W = `ADV_DATA_W;

  // ----------------------------------------
  // Start-up sequencer states, one-hot
  // ----------------------------------------
  // Settle and sample cover the two synchroniser stages
  localparam [3:0] ST_SETTLE = 4'h1;
  localparam [3:0] ST_SAMPLE = 4'h2;
  localparam [3:0] ST_LOAD = 4'h4;
  localparam [3:0] ST_RUN = 4'h8;

  // ----------------------------------------
  // Default value from latched straps
  // ----------------------------------------
  // Fiber mode clears the pause and 10BASE-T bits regardless of straps
  function [`ADV_DATA_W-1:0] strap_default;
    input [`ADV_STRAP_W-1:0] s;
    reg [`ADV_DATA_W-1:0] v;
    reg manual_fc;
    reg fd_fc;
    reg an;
    reg spd;
    reg dup;
    reg fiber;
    begin
      manual_fc = s[`STRAP_MANUAL_FC];
      fd_fc = s[`STRAP_FD_FC];
      an = s[`STRAP_AUTONEG];
      spd = s[`STRAP_SPEED];
      dup = s[`STRAP_DUPLEX];
      fiber = s[`STRAP_FIBER];

      // Fixed part: next page, fault and 100BASE-X bits, selector
      v = `ADV_FIXED_RESET;
      if (!fiber) begin
        v[`ADV_SYM_PAUSE] = ~manual_fc;
        v[`ADV_ASYM_PAUSE] = ~manual_fc & fd_fc;
        v[`ADV_10_FD] = an | (~spd & dup);
        v[`ADV_10_HD] = an | ~spd;
      end
      strap_default = v;
    end
  endfunction

  // ----------------------------------------
  // Write data with read-only bits cleared
  // ----------------------------------------
  // Reserved bits 14 and 9 never take write data
  // Bit 12 stays writable; software keeps it at zero
  function [`ADV_DATA_W-1:0] masked_write;
    input [`ADV_DATA_W-1:0] d;
    reg [`ADV_DATA_W-1:0] v;
    begin
      v = `ADV_ZERO16;
      v[`ADV_NEXT_PAGE] = d[`ADV_NEXT_PAGE];
      v[`ADV_REMOTE_FAULT] = d[`ADV_REMOTE_FAULT];
      v[`ADV_EXT_NEXT_PAGE] = d[`ADV_EXT_NEXT_PAGE];
      v[`ADV_ASYM_PAUSE] = d[`ADV_ASYM_PAUSE];
      v[`ADV_SYM_PAUSE] = d[`ADV_SYM_PAUSE];
      v[`ADV_100_FD] = d[`ADV_100_FD];
      v[`ADV_100_HD] = d[`ADV_100_HD];
      v[`ADV_10_FD] = d[`ADV_10_FD];
      v[`ADV_10_HD] = d[`ADV_10_HD];
      v[`ADV_SEL_HI:`ADV_SEL_LO] = d[`ADV_SEL_HI:`ADV_SEL_LO];
      masked_write = v;
    end
  endfunction

  // ----------------------------------------
  // Register index decode
  // ----------------------------------------
  // Low address bits pick the register, the top bit picks the PHY
  function index_hit;
    input [`ADV_ADDR_W-1:0] a;
    begin
      index_hit = (a[`ADV_PHY_SEL_BIT-1:0] == `ADV_INDEX);
    end
  endfunction

  function hit;
    input [`ADV_ADDR_W-1:0] a;
    input phy;
    begin
      hit = index_hit(a) & (a[`ADV_PHY_SEL_BIT] == phy);
    end
  endfunction

  // ----------------------------------------
  // Strap bundles, one group per PHY
  // ----------------------------------------
  wire [STRAP_W-1:0] strap_a;
  wire [STRAP_W-1:0] strap_b;
  wire [SYNC_W-1:0] strap_raw;
  wire [SYNC_W-1:0] strap_sync;

  // PHY A straps
  assign strap_a[`STRAP_MANUAL_FC] = manual_flow_ctl_cfg_a;
  assign strap_a[`STRAP_FD_FC] = full_duplex_flow_ctl_cfg_a;
  assign strap_a[`STRAP_AUTONEG] = autoneg_cfg_a;
  assign strap_a[`STRAP_SPEED] = speed_cfg_a;
  assign strap_a[`STRAP_DUPLEX] = duplex_cfg_a;
  assign strap_a[`STRAP_FIBER] = fiber_mode_a;

  // PHY B straps
  assign strap_b[`STRAP_MANUAL_FC] = manual_flow_ctl_cfg_b;
  assign strap_b[`STRAP_FD_FC] = full_duplex_flow_ctl_cfg_b;
  assign strap_b[`STRAP_AUTONEG] = autoneg_cfg_b;
  assign strap_b[`STRAP_SPEED] = speed_cfg_b;
  assign strap_b[`STRAP_DUPLEX] = duplex_cfg_b;
  assign strap_b[`STRAP_FIBER] = fiber_mode_b;

  assign strap_raw = {strap_b, strap_a};

  // ----------------------------------------
  // Two-stage synchroniser per strap bit
  // ----------------------------------------
  // Straps are asynchronous pins; only the second stage is read
  // Reset clears both stages; the sequencer waits them out
  genvar b;
  generate
    for (b = 0; b < SYNC_W; b = b + 1) begin : strap_sync_bit
      reg meta_q;
      reg stable_q;

      always @(posedge clk or posedge reset) begin
        if (reset) begin
          meta_q <= 1'b0;
          stable_q <= 1'b0;
        end else begin
          meta_q <= strap_raw[b];
          stable_q <= meta_q;
        end
      end

      assign strap_sync[b] = stable_q;
    end
  endgenerate

  // ----------------------------------------
  // Start-up sequencer
  // ----------------------------------------
  // Defaults load once, on the third edge after reset release,
  // when the synchroniser holds the strap levels
  reg [3:0] state_q;
  reg [3:0] state_d;
  wire load_defaults;

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_SETTLE: begin
        state_d = ST_SAMPLE;
      end
      ST_SAMPLE: begin
        state_d = ST_LOAD;
      end
      ST_LOAD: begin
        state_d = ST_RUN;
      end
      ST_RUN: begin
        state_d = ST_RUN;
      end
      default: begin
        state_d = ST_SETTLE;
      end
    endcase
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_SETTLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign load_defaults = (state_q == ST_LOAD);

  // ----------------------------------------
  // Write decode, one strobe per PHY
  // ----------------------------------------
  wire [N_PHY-1:0] wr_sel;
  genvar g;

  generate
    for (g = 0; g < N_PHY; g = g + 1) begin : phy_wr
      assign wr_sel[g] = reg_write & hit(reg_addr, g == `ADV_PHY_B);
    end
  endgenerate

  // ----------------------------------------
  // Next value of each PHY copy
  // ----------------------------------------
  // Default load wins over a write in the same cycle
  wire [N_PHY*DATA_W-1:0] adv_d;
  wire [N_PHY*DATA_W-1:0] adv_flat;

  generate
    for (g = 0; g < N_PHY; g = g + 1) begin : phy_copy
      wire [STRAP_W-1:0] latched;
      wire [DATA_W-1:0] dflt;
      wire [DATA_W-1:0] current;
      wire [DATA_W-1:0] written;
      wire sel;
      reg [DATA_W-1:0] next_d;

      assign latched = strap_sync[g*STRAP_W +: STRAP_W];
      assign dflt = strap_default(latched);
      assign current = adv_flat[g*DATA_W +: DATA_W];
      assign written = masked_write(reg_wdata);
      assign sel = wr_sel[g];

      always @* begin
        next_d = current;
        if (load_defaults) begin
          next_d = dflt;
        end else if (sel) begin
          next_d = written;
        end
      end

      assign adv_d[g*DATA_W +: DATA_W] = next_d;
    end
  endgenerate

  // ----------------------------------------
  // Register storage, one word per PHY
  // ----------------------------------------
  // Reset holds the fixed part; strap bits follow after release
  reg [DATA_W-1:0] adv_q [0:N_PHY-1];
  integer k;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      for (k = 0; k < N_PHY; k = k + 1) begin
        adv_q[k] <= `ADV_FIXED_RESET;
      end
    end else begin
      for (k = 0; k < N_PHY; k = k + 1) begin
        adv_q[k] <= adv_d[k*DATA_W +: DATA_W];
      end
    end
  end

  // Flat view feeds the next-value logic above
  generate
    for (g = 0; g < N_PHY; g = g + 1) begin : phy_view
      assign adv_flat[g*DATA_W +: DATA_W] = adv_q[g];
    end
  endgenerate

  // ----------------------------------------
  // Advertised abilities to auto-negotiation
  // ----------------------------------------
  // Live values, seen by auto-negotiation without delay
  assign advert_a = adv_q[`ADV_PHY_A];
  assign advert_b = adv_q[`ADV_PHY_B];

  // ----------------------------------------
  // Read select
  // ----------------------------------------
  wire rd_hit;
  wire rd_phy;

  assign rd_hit = reg_read & index_hit(reg_addr);
  assign rd_phy = reg_addr[`ADV_PHY_SEL_BIT];

  // ----------------------------------------
  // Read data, one cycle after strobe
  // ----------------------------------------
  // Idle cycles and unmapped indices read as zero
  reg [DATA_W-1:0] rdata_d;

  always @* begin
    rdata_d = `ADV_ZERO16;
    if (rd_hit) begin
      rdata_d = adv_q[rd_phy];
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= `ADV_ZERO16;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

endmodule

// [strap_src.sv]
// Strap level model for one PHY
`timescale 1ns/1ps
module strap_src (
  // Strap levels
  input wire [5:0] cfg,
  output wire [5:0] pin
);
  assign pin = cfg;
endmodule

// [phy_adv_asserts.sv]
// Checker for the advertisement bank
`timescale 1ns/1ps
module phy_adv_chk (
  // Bus
  input wire clk,
  input wire reset,
  input wire [4:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  input wire [15:0] reg_rdata,
  // Values
  input wire [15:0] advert_a,
  input wire [15:0] advert_b
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_wr_a: assert property (reg_write && reg_addr == 5'h04 |=>
    advert_a == ($past(reg_wdata) & 16'hbdff)) else $error("wr a");
  a_wr_b: assert property (reg_write && reg_addr == 5'h14 |=>
    advert_b == ($past(reg_wdata) & 16'hbdff)) else $error("wr b");
  a_rd_a: assert property (reg_read && reg_addr == 5'h04 |=>
    reg_rdata == $past(advert_a)) else $error("rd a");
  a_rd_b: assert property (reg_read && reg_addr == 5'h14 |=>
    reg_rdata == $past(advert_b)) else $error("rd b");
  a_rd_idle: assert property (!reg_read |=> reg_rdata == 0) else $error("idle");
  a_rsvd_zero: assert property (((advert_a | advert_b) & 16'h4200) == 0)
    else $error("rsvd");
  a_unmap_rd: assert property (reg_read && reg_addr[3:0] != 4 |=>
    reg_rdata == 0) else $error("unmap rd");
  a_unmap_wr: assert property (reg_write && reg_addr[3:0] != 4 |=>
    $stable(advert_a) && $stable(advert_b)) else $error("unmap wr");
endmodule
bind phy_autoneg_advert_reg phy_adv_chk u_chk (.clk, .reset, .reg_addr, .reg_wdata,
  .reg_write, .reg_read, .reg_rdata, .advert_a, .advert_b);

// [phy_autoneg_advert_reg_tb.sv]
// Bench for the advertisement bank
`timescale 1ns/1ps
module phy_autoneg_advert_reg_tb;
  reg clk = 0, reset = 1, reg_write = 0, reg_read = 0;
  reg [4:0] reg_addr = 0;
  reg [15:0] reg_wdata = 0;
  reg [5:0] sa = 0, sb = 0;
  wire [15:0] reg_rdata, advert_a, advert_b;
  wire [5:0] pa, pb;
  integer n_mismatch = 0, checks_done = 0, i;
  strap_src u_sa (.cfg(sa), .pin(pa));
  strap_src u_sb (.cfg(sb), .pin(pb));
  phy_autoneg_advert_reg u_dut (.clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .advert_a, .advert_b, .manual_flow_ctl_cfg_a(pa[5]),
    .full_duplex_flow_ctl_cfg_a(pa[4]), .autoneg_cfg_a(pa[3]), .speed_cfg_a(pa[2]),
    .duplex_cfg_a(pa[1]), .fiber_mode_a(pa[0]), .manual_flow_ctl_cfg_b(pb[5]),
    .full_duplex_flow_ctl_cfg_b(pb[4]), .autoneg_cfg_b(pb[3]), .speed_cfg_b(pb[2]),
    .duplex_cfg_b(pb[1]), .fiber_mode_b(pb[0]));
  initial forever #4 clk = ~clk;
  function [15:0] dflt(input [5:0] s);
    begin
      dflt = 16'h0181;
      if (!s[0]) begin
        dflt[10] = !s[5];
        dflt[11] = !s[5] & s[4];
        dflt[6] = s[3] | (!s[2] & s[1]);
        dflt[5] = s[3] | !s[2];
      end
    end
  endfunction
  task chk(input [63:0] what, input [15:0] seen, input [15:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("MISMATCH %0s exp %h seen %h", what, exp, seen);
      end
    end
  endtask
  task wr(input [4:0] a, input [15:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1;
      @(posedge clk);
      reg_write <= 0;
    end
  endtask
  task rd(input [4:0] a, input [15:0] exp);
    begin
      reg_addr <= a;
      reg_read <= 1;
      @(posedge clk);
      reg_read <= 0;
      #1 chk("rdata", reg_rdata, exp);
      @(posedge clk);
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    for (i = 0; i < 64; i = i + 1) begin
      sa <= i[5:0];
      sb <= ~i[5:0];
      reset <= 1;
      repeat (2) @(posedge clk);
      reset <= 0;
      repeat (4) @(posedge clk);
      rd(5'h04, dflt(i[5:0]));
      rd(5'h14, dflt(~i[5:0]));
      chk("advert_a", advert_a, dflt(i[5:0]));
      chk("advert_b", advert_b, dflt(~i[5:0]));
    end
    $display("defaults done");
    wr(5'h04, 16'hefff);
    rd(5'h04, 16'hadff);
    rd(5'h14, 16'h05a1);
    wr(5'h05, 16'hffff);
    rd(5'h05, 16'h0000);
    chk("advert_a", advert_a, 16'hadff);
    chk("advert_b", advert_b, 16'h05a1);
    wr(5'h14, 16'h4321);
    rd(5'h14, 16'h0121);
    chk("advert_b", advert_b, 16'h0121);
    chk("advert_a", advert_a, 16'hadff);
    $display("access done");
    complete_run;
  end
endmodule
